//--- rtl/sfsp_top.sv
// Purpose: flow-through synchronous burst sram port with its storage core
// Assumes: all host inputs synchronous to clk_sys_i; dq is resolved outside
// Notes:   read data leaves combinationally from the registered address
//
// Function
// - register all command inputs on rising edge; mode and sleep request also act unregistered
// - clock gate high freezes all state except under synchronous reset
// - write strobe plus byte lanes, self-timed write
// - drivers off during every write data phase
// - three chip selects; output enable acts asynchronously
// - back-to-back reads and writes, no wait states
// - read data flows through without output register
// - internal driver control; output enable may stay on
// - interleaved order when mode high, else linear
// - low power on sleep request or deselect
`include "sfsp_defs.svh"

module sfsp_top (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic clock_gate_in_n_i,
   input wire sfsp_pkg::sfsp_cmd_t cmd_i,
   input wire logic oe_n_i,
   input wire logic burst_interleave_i,
   input wire logic sleep_request_i,
   input wire logic [`SFSP_DATA_W-1:0] dq_i,
   output logic [`SFSP_DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   output logic low_power_o
);
   import sfsp_pkg::*;

   localparam int DEPTH = 1 << `SFSP_ADDR_W;

   sfsp_state_t r;
   sfsp_state_t r_nxt;
   logic step;
   logic selected;
   logic [`SFSP_BURST_W-1:0] addr_lo;
   logic [`SFSP_ADDR_W-1:0] addr_eff;
   logic [`SFSP_DATA_W-1:0] rd_data;
   logic wr_commit;

   // the clock gate turns an edge into an extension of the previous cycle
   assign step = !clock_gate_in_n_i;
   assign selected = !cmd_i.ce1_n && cmd_i.ce2 && !cmd_i.ce3_n;

   sfsp_burst_seq u_burst (
      .base_i(r.base),
      .cnt_i(r.cnt),
      .interleave_i(burst_interleave_i),
      .lo_o(addr_lo)
   );

   assign addr_eff = {r.addr_hi, addr_lo};

   always_comb begin
      r_nxt = r;
      if (step) begin
         // byte lanes are sampled every beat, so a burst may change its mask
         r_nxt.bw_n = cmd_i.byte_lane_write_sel_n;
         if (sleep_request_i) begin
            r_nxt.op = SFSP_ST_IDLE;
         end else if (cmd_i.adv_ld) begin
            case (r.op)
               SFSP_ST_READ, SFSP_ST_WRITE: begin
                  r_nxt.cnt = r.cnt + 2'h1;
               end
               SFSP_ST_IDLE: begin
                  r_nxt.op = SFSP_ST_IDLE;
               end
               default: begin
                  r_nxt.op = SFSP_ST_IDLE;
               end
            endcase
         end else if (selected) begin
            // a new access is taken every cycle, whatever the previous one was
            r_nxt.op = cmd_i.we_n ? SFSP_ST_READ : SFSP_ST_WRITE;
            r_nxt.addr_hi = cmd_i.addr[`SFSP_ADDR_W-1:`SFSP_BURST_W];
            r_nxt.base = cmd_i.addr[`SFSP_BURST_W-1:0];
            r_nxt.cnt = `SFSP_CNT_RST;
         end else begin
            r_nxt.op = SFSP_ST_IDLE;
         end
      end
      if (srst_i) begin
         r_nxt.op = SFSP_ST_IDLE;
         r_nxt.addr_hi = '0;
         r_nxt.base = `SFSP_CNT_RST;
         r_nxt.cnt = `SFSP_CNT_RST;
         r_nxt.bw_n = `SFSP_BW_RST;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      r <= r_nxt;
   end

   // write data arrives in the cycle after its address and is stored at the
   // next enabled edge, so no separate write pulse timing is needed
   assign wr_commit = step && !srst_i && (r.op == SFSP_ST_WRITE);

   genvar gl;
   generate
      for (gl = 0; gl < `SFSP_LANES; gl++) begin : g_lane
         logic [`SFSP_LANE_W-1:0] lane_mem [DEPTH];
         always_ff @(posedge clk_sys_i) begin
            if (wr_commit && !r.bw_n[gl]) begin
               lane_mem[addr_eff] <= dq_i[gl*`SFSP_LANE_W +: `SFSP_LANE_W];
            end
         end
         assign rd_data[gl*`SFSP_LANE_W +: `SFSP_LANE_W] = lane_mem[addr_eff];
      end
   endgenerate

   // no output stage: the word is valid within the cycle after the address edge
   assign dq_o = rd_data;
   // drivers follow the registered op, so the host can leave oe_n_i low
   assign dq_oe_o = (r.op == SFSP_ST_READ) && !oe_n_i;
   assign low_power_o = sleep_request_i || (r.op == SFSP_ST_IDLE);

   // ---------------- checks ----------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);

   logic load_rd;
   logic load_wr;
   assign load_rd = step && !sleep_request_i && !cmd_i.adv_ld && selected && cmd_i.we_n;
   assign load_wr = step && !sleep_request_i && !cmd_i.adv_ld && selected && !cmd_i.we_n;

   AST_CAPTURE_ADDR: assert property (
      (load_rd || load_wr) |=> ({r.addr_hi, r.base} == $past(cmd_i.addr)) && (r.cnt == 2'h0))
      else $error("loaded address not captured");

   AST_STALL_HOLD: assert property (
      clock_gate_in_n_i |=> $stable(r))
      else $error("state moved while clock gate was high");

   AST_WRITE_LANE0: assert property (
      (wr_commit && !r.bw_n[0]) |=>
         (g_lane[0].lane_mem[$past(addr_eff)] == $past(dq_i[`SFSP_LANE_W-1:0])))
      else $error("enabled byte lane not written");

   AST_WRITE_MASKED: assert property (
      (wr_commit && r.bw_n[1]) |=>
         (g_lane[1].lane_mem[$past(addr_eff)] == $past(g_lane[1].lane_mem[addr_eff])))
      else $error("masked byte lane was written");

   AST_NO_DRIVE_WRITE: assert property (
      load_wr |=> !dq_oe_o)
      else $error("drivers on during write data phase");

   AST_OE_ASYNC: assert property (
      oe_n_i |-> !dq_oe_o)
      else $error("drivers on while output enable high");

   AST_NO_WAIT: assert property (
      (load_rd ##1 load_wr) |=> (r.op == SFSP_ST_WRITE) && ($past(r.op) == SFSP_ST_READ))
      else $error("read to write turnaround inserted a wait");

   // the word must belong to the address taken at the previous edge, not a later one
   AST_READ_FLOW: assert property (
      load_rd |=> (r.op == SFSP_ST_READ) && (addr_eff == $past(cmd_i.addr)) &&
         (dq_o == {g_lane[1].lane_mem[$past(cmd_i.addr)],
                   g_lane[0].lane_mem[$past(cmd_i.addr)]}))
      else $error("read data not flowing through");

   AST_DRIVE_READ: assert property (
      (load_rd ##1 !oe_n_i) |-> dq_oe_o)
      else $error("read data not driven with output enable low");

   AST_ORDER_INTLV: assert property (
      burst_interleave_i |-> (addr_lo == (r.base ^ r.cnt)))
      else $error("interleaved order wrong");

   AST_ORDER_LIN: assert property (
      !burst_interleave_i |-> (addr_lo == 2'(r.base + r.cnt)))
      else $error("linear order wrong");

   AST_SLEEP_DESEL: assert property (
      (step && !cmd_i.adv_ld && !selected) or (step && sleep_request_i) |=>
         low_power_o && (r.op == SFSP_ST_IDLE))
      else $error("no low power after deselect or sleep");

   AST_BURST_WRAP: assert property (
      (load_rd ##1 (step && cmd_i.adv_ld && !sleep_request_i) [*4]) |=>
         (r.cnt == 2'h0) && (r.op == SFSP_ST_READ))
      else $error("burst counter did not wrap after four beats");

   CV_READ_BURST: cover property (load_rd ##1 (step && cmd_i.adv_ld) [*3]);
   CV_WRITE_READ: cover property (load_wr ##1 load_rd ##1 dq_oe_o);
   CV_STALL: cover property (load_wr ##1 clock_gate_in_n_i [*2] ##1 step);
   CV_SLEEP: cover property (load_rd ##1 (step && sleep_request_i) ##1 low_power_o);

endmodule : sfsp_top

//--- rtl/sfsp_defs.svh
// Purpose: constants of the flow-through synchronous sram port
// Assumes: x18 organisation, two byte lanes of nine bits
// Notes:   definitions only
`ifndef SFSP_DEFS_SVH
`define SFSP_DEFS_SVH

// word address width of the x18 core
`define SFSP_ADDR_W 22
`define SFSP_DATA_W 18
`define SFSP_LANES 2
`define SFSP_LANE_W 9
// burst counter covers the two low address bits
`define SFSP_BURST_W 2
`define SFSP_CNT_RST 2'h0
`define SFSP_BW_RST 2'h3

`endif

//--- rtl/sfsp_pkg.sv
// Purpose: shared types of the flow-through synchronous sram port
// Assumes: sfsp_defs.svh gives all widths
// Notes:   state encoding is gray along idle, read, write
`include "sfsp_defs.svh"

package sfsp_pkg;

   typedef enum logic [1:0] {
      SFSP_ST_IDLE  = 2'h0,
      SFSP_ST_READ  = 2'h1,
      SFSP_ST_WRITE = 2'h3
   } sfsp_op_t;

   // one cycle of host control, sampled on an enabled rising edge
   typedef struct packed {
      logic [`SFSP_ADDR_W-1:0] addr;
      logic adv_ld;
      logic we_n;
      logic [`SFSP_LANES-1:0] byte_lane_write_sel_n;
      logic ce1_n;
      logic ce2;
      logic ce3_n;
   } sfsp_cmd_t;

   typedef struct packed {
      sfsp_op_t op;
      logic [`SFSP_ADDR_W-1:`SFSP_BURST_W] addr_hi;
      logic [`SFSP_BURST_W-1:0] base;
      logic [`SFSP_BURST_W-1:0] cnt;
      logic [`SFSP_LANES-1:0] bw_n;
   } sfsp_state_t;

endpackage : sfsp_pkg

//--- rtl/sfsp_burst_seq.sv
// Purpose: low address bits of the current burst beat
// Assumes: base is the loaded address, cnt the beats since load
// Notes:   purely combinational
`include "sfsp_defs.svh"

module sfsp_burst_seq (
   input wire logic [`SFSP_BURST_W-1:0] base_i,
   input wire logic [`SFSP_BURST_W-1:0] cnt_i,
   input wire logic interleave_i,
   output logic [`SFSP_BURST_W-1:0] lo_o
);
   import sfsp_pkg::*;

   always_comb begin
      // both orders wrap inside the four-word block
      if (interleave_i) begin
         lo_o = base_i ^ cnt_i;
      end else begin
         lo_o = base_i + cnt_i;
      end
   end

endmodule : sfsp_burst_seq

//--- verif/sfsp_host_model.sv
// Purpose: host controller side of the sram data wire
// Assumes: write data goes out on the same enabled edge that takes the write
// Notes:   an undriven wire shows the inverse of its last level
`include "sfsp_defs.svh"
module sfsp_host_model (
   input wire logic clk_sys_i,
   input wire logic clock_gate_in_n_i,
   input wire logic wr_i,
   input wire logic [`SFSP_DATA_W-1:0] wd_i,
   input wire logic dq_oe_i,
   input wire logic [`SFSP_DATA_W-1:0] dq_o_i,
   output logic [`SFSP_DATA_W-1:0] dq_bus_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drv_r = 1'b0;
   logic [`SFSP_DATA_W-1:0] wd_r = '0;
   logic [`SFSP_DATA_W-1:0] last_r = '0;
   // a stall stretches the data phase, so only enabled edges move it
   always @(posedge clk_sys_i) begin
      if (!clock_gate_in_n_i) begin
         drv_r <= wr_i;
         wd_r <= wd_i;
      end
      last_r <= dq_bus_o;
   end
   // no keeper on the wire: a released bus must not repeat its old value
   assign dq_bus_o = dq_oe_i ? dq_o_i : (drv_r ? wd_r : ~last_r);
endmodule : sfsp_host_model

//--- verif/sfsp_top_tb.sv
// Purpose: self-checking bench of the flow-through sram port
// Assumes: each row shows the cycle after it is taken
// Notes:   stall, output enable, sleep and reset follow the rows
`include "sfsp_defs.svh"
module sfsp_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import sfsp_pkg::*;
   localparam int DW = `SFSP_DATA_W;
   typedef struct {
      sfsp_cmd_t c;
      logic [DW-1:0] wd;
      logic ilv;
      logic oe;
      logic lp;
      logic [DW-1:0] e;
   } sfsp_row_t;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic gate_n = 1'b0;
   sfsp_cmd_t cmd = '0;
   logic oe_n = 1'b0;
   logic ilv = 1'b0;
   logic sleep = 1'b0;
   logic wr = 1'b0;
   logic [DW-1:0] wd = '0;
   logic [DW-1:0] dq_bus;
   logic [DW-1:0] dq_o;
   logic dq_oe;
   logic low_power;
   int fail_count = 0;
   int total_checks = 0;
   sfsp_row_t rows [10];
   sfsp_top dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .clock_gate_in_n_i(gate_n),
      .cmd_i(cmd), .oe_n_i(oe_n), .burst_interleave_i(ilv), .sleep_request_i(sleep),
      .dq_i(dq_bus), .dq_o(dq_o), .dq_oe_o(dq_oe), .low_power_o(low_power));
   sfsp_host_model host_u (.clk_sys_i(clk_sys_i), .clock_gate_in_n_i(gate_n), .wr_i(wr),
      .wd_i(wd), .dq_oe_i(dq_oe), .dq_o_i(dq_o), .dq_bus_o(dq_bus));
   function automatic sfsp_row_t mk(logic [7:0] a, logic adv, logic we_n, logic [1:0] bw,
         logic sel, logic [DW-1:0] d, logic i, logic oe, logic lp, logic [DW-1:0] e);
      sfsp_row_t r;
      r.c = '{`SFSP_ADDR_W'(a), adv, we_n, bw, 1'b0, sel, 1'b0};
      r.wd = d;
      r.ilv = i;
      r.oe = oe;
      r.lp = lp;
      r.e = e;
      return r;
   endfunction : mk
   task automatic chk(string name, logic [DW-1:0] seen, logic [DW-1:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test
   initial begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (400) @(posedge clk_sys_i);
      fail_count++;
      finish_test();
   end
   initial begin
      rows[0] = mk(4, 0, 0, 2'h0, 1, 18'h2A5A5, 0, 0, 0, 0);
      rows[1] = mk(0, 1, 0, 2'h0, 1, 18'h11111, 0, 0, 0, 0);
      rows[2] = mk(4, 0, 1, 2'h3, 1, 0, 0, 1, 0, 18'h2A5A5);
      rows[3] = mk(0, 1, 1, 2'h3, 1, 0, 0, 1, 0, 18'h11111);
      rows[4] = mk(4, 0, 0, 2'h1, 1, 0, 0, 0, 0, 0);
      rows[5] = mk(4, 0, 1, 2'h3, 1, 0, 0, 1, 0, 18'h001A5);
      rows[6] = mk(0, 0, 1, 2'h3, 0, 0, 1, 0, 1, 0);
      rows[7] = mk(5, 0, 1, 2'h3, 1, 0, 1, 1, 0, 18'h11111);
      rows[8] = mk(0, 1, 1, 2'h3, 1, 0, 1, 1, 0, 18'h001A5);
      rows[9] = mk(0, 0, 1, 2'h3, 0, 0, 1, 0, 1, 0);
      repeat (20) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      for (int i = 0; i <= 10; i++) begin
         @(posedge clk_sys_i);
         if (i < 10) begin
            cmd <= rows[i].c;
            wd <= rows[i].wd;
            wr <= !rows[i].c.we_n;
            ilv <= rows[i].ilv;
         end
         @(negedge clk_sys_i);
         if (i > 0) begin
            chk("dq_oe", dq_oe, rows[i-1].oe);
            chk("low_power", low_power, rows[i-1].lp);
            if (rows[i-1].oe) chk("dq", dq_o, rows[i-1].e);
         end
      end
      @(posedge clk_sys_i);
      cmd <= rows[7].c;
      @(posedge clk_sys_i);
      gate_n <= 1'b1;
      cmd <= rows[5].c;
      repeat (3) begin
         @(negedge clk_sys_i);
         chk("stall_dq", dq_o, 18'h11111);
      end
      @(posedge clk_sys_i);
      oe_n <= 1'b1;
      @(negedge clk_sys_i);
      chk("oe_off", dq_oe, 0);
      @(posedge clk_sys_i);
      oe_n <= 1'b0;
      gate_n <= 1'b0;
      @(posedge clk_sys_i);
      sleep <= 1'b1;
      @(negedge clk_sys_i);
      chk("sleep_lp", low_power, 1);
      chk("sleep_dq", dq_o, 18'h001A5);
      @(negedge clk_sys_i);
      chk("sleep_oe", dq_oe, 0);
      @(posedge clk_sys_i);
      sleep <= 1'b0;
      cmd <= rows[7].c;
      @(posedge clk_sys_i);
      srst_i <= 1'b1;
      @(negedge clk_sys_i);
      chk("pre_rst_oe", dq_oe, 1);
      @(posedge clk_sys_i);
      srst_i <= 1'b0;
      @(negedge clk_sys_i);
      chk("rst_oe", dq_oe, 0);
      chk("rst_lp", low_power, 1);
      @(posedge clk_sys_i);
      cmd.ce3_n <= 1'b1;
      @(negedge clk_sys_i);
      chk("first_rd_oe", dq_oe, 1);
      chk("first_rd_dq", dq_o, 18'h11111);
      @(negedge clk_sys_i);
      chk("desel3_lp", low_power, 1);
      chk("desel3_oe", dq_oe, 0);
      finish_test();
   end
endmodule : sfsp_top_tb
